// >>> inc/sadc_pkg.sv
package sadc_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] SCR_IDX = 8'h3C;
  localparam logic [7:0] RES_IDX = 8'h3D;
  localparam logic [7:0] DIV_IDX = 8'h3E;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // status and control field layout
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CHAN_MSB = 4;
  localparam logic [7:0] SCR_RST = 8'h1F;

  // clock divider field layout
  localparam int PRESC_LSB = 5;
  localparam int PRESC_MSB = 7;
  localparam logic [2:0] PRESC_RST = 3'h0;

  // channel selector codes
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [4:0] CHAN_VDD = 5'h1D;
  localparam logic [4:0] CHAN_VSS = 5'h1E;
  localparam logic [4:0] CHAN_DED = 5'h0C;
  localparam logic [4:0] CHAN_PD_FIRST = 5'h08;
  localparam logic [4:0] CHAN_PD_LAST = 5'h0B;

  // conversion timing, in converter clock cycles
  localparam logic [3:0] CONV_CYCLES = 4'hE;
  localparam logic [3:0] LAST_STEP = 4'hD;
  localparam logic [3:0] MARK_STEP = 4'h5;
  localparam logic [3:0] FIRST_STEP = 4'h1;

  // prescaler divide ratios minus one
  localparam logic [3:0] DIV1_M1 = 4'h0;
  localparam logic [3:0] DIV2_M1 = 4'h1;
  localparam logic [3:0] DIV4_M1 = 4'h3;
  localparam logic [3:0] DIV8_M1 = 4'h7;
  localparam logic [3:0] DIV16_M1 = 4'hF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_CONVERT} sadcSeq_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } sadcAxiReq_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } sadcAxiRsp_t;

  typedef struct packed {
    logic cmpAbove;
    logic stopMode;
    logic [7:0] portBDir;
    logic [7:0] portBLatch;
    logic [7:0] portBPin;
    logic [3:0] portDDir;
    logic [3:0] portDLatch;
    logic [3:0] portDPin;
  } sadcPinsIn_t;

  typedef struct packed {
    logic [4:0] analogSelect;
    logic converterOn;
    logic [7:0] portBAnalog;
    logic [3:0] portDLowAnalog;
    logic dedicatedSel;
    logic refSupplySel;
    logic refGroundSel;
    logic [7:0] sarTrial;
    logic [7:0] portBRead;
    logic [3:0] portDLowRead;
    logic irqReq;
  } sadcPinsOut_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } sadcPresc_t;

  typedef struct packed {
    sadcAxiRsp_t rsp;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic irqEn;
    logic cont;
    logic [4:0] chan;
    logic [2:0] presc;
    logic flag;
    logic [7:0] result;
    sadcSeq_t seq;
    logic [3:0] cnt;
    logic [7:0] trial;
    sadcPinsOut_t pins;
  } sadcCore_t;

endpackage

// >>> design/sadc_prescaler.sv
`timescale 1ns/1ps

// free-running divider of the bus clock, one-cycle tick per converter clock
module sadc_prescaler
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] presc,
  output logic tick
);

  sadc_pkg::sadcPresc_t st_q;
  sadc_pkg::sadcPresc_t st_d;

  // top bit set always means divide by 16
  function automatic logic [3:0] divMinusOne(input logic [2:0] sel);
    logic [3:0] r;
    r = sadc_pkg::DIV16_M1;
    if (sel == 3'h0)
      r = sadc_pkg::DIV1_M1;
    else if (sel == 3'h1)
      r = sadc_pkg::DIV2_M1;
    else if (sel == 3'h2)
      r = sadc_pkg::DIV4_M1;
    else if (sel == 3'h3)
      r = sadc_pkg::DIV8_M1;
    return r;
  endfunction

  // counter wraps early if the ratio shrinks, so no long dead stretch
  always_comb
  begin
    st_d = st_q;
    if (st_q.cnt >= divMinusOne(presc))
    begin
      st_d.cnt = 4'h0;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 4'h1;
      st_d.tick = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tick = st_q.tick;

endmodule

// >>> design/sadc_sequencer.sv
`timescale 1ns/1ps

module sadc_sequencer
(
  input wire logic mclk,
  input wire logic arst_n,
  input sadc_pkg::sadcAxiReq_t axiReq,
  output sadc_pkg::sadcAxiRsp_t axiRsp,
  input sadc_pkg::sadcPinsIn_t pinsIn,
  output sadc_pkg::sadcPinsOut_t pinsOut
);

  sadc_pkg::sadcCore_t core_q;
  sadc_pkg::sadcCore_t core_d;
  logic tick;
  logic doneNow;
  logic scrWrite;
  logic resRead;

  // register index of a byte address; upper bits must be zero
  function automatic logic hitIdx(input logic [sadc_pkg::ADDR_W-1:0] a,
                                  input logic [7:0] idx);
    return (a[sadc_pkg::IDX_MSB:sadc_pkg::IDX_LSB] == idx) &&
           (a[sadc_pkg::ADDR_W-1:sadc_pkg::IDX_MSB+1] == '0) &&
           (a[sadc_pkg::IDX_LSB-1:0] == '0);
  endfunction

  function automatic logic chanOff(input logic [4:0] ch);
    return ch == sadc_pkg::CHAN_OFF;
  endfunction

  // one successive approximation step; decides bit LAST_STEP-c
  function automatic logic [7:0] sarStep(input logic [7:0] t,
                                         input logic [3:0] c,
                                         input logic cmp);
    logic [7:0] r;
    logic [3:0] b;
    r = t;
    b = sadc_pkg::LAST_STEP - c;
    if (c == sadc_pkg::MARK_STEP)
      r[7] = 1'b1;
    else if (c > sadc_pkg::MARK_STEP)
    begin
      r[b[2:0]] = cmp;
      if (b != 4'h0)
        r[b[2:0] - 3'h1] = 1'b1;
    end
    return r;
  endfunction

  sadc_prescaler u_presc
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .presc(core_q.presc),
    .tick(tick)
  );

  // bus slave, sequencer and pin logic in one next-state process
  always_comb
  begin
    core_d = core_q;
    doneNow = 1'b0;
    scrWrite = 1'b0;
    resRead = 1'b0;

    // write address and data are taken in either order
    if (axiReq.awvalid && core_q.rsp.awready)
    begin
      core_d.awHeld = 1'b1;
      core_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && core_q.rsp.wready)
    begin
      core_d.wHeld = 1'b1;
      core_d.wData = axiReq.wdata[7:0];
      core_d.wLane0 = axiReq.wstrb[0];
    end
    if (core_q.rsp.bvalid && axiReq.bready)
      core_d.rsp.bvalid = 1'b0;
    if (core_q.rsp.rvalid && axiReq.rready)
      core_d.rsp.rvalid = 1'b0;

    // sequencer; stop mode overrides the converter clock
    if (pinsIn.stopMode)
    begin
      if (core_q.seq == sadc_pkg::SEQ_CONVERT)
        core_d.seq = sadc_pkg::SEQ_ARMED;
    end
    else if (chanOff(core_q.chan))
      core_d.seq = sadc_pkg::SEQ_IDLE;
    else if (tick)
    begin
      if (core_q.seq == sadc_pkg::SEQ_ARMED)
      begin
        core_d.seq = sadc_pkg::SEQ_CONVERT;
        core_d.cnt = sadc_pkg::FIRST_STEP;
        core_d.trial = 8'h00;
      end
      else if (core_q.seq == sadc_pkg::SEQ_CONVERT)
      begin
        core_d.trial = sarStep(core_q.trial, core_q.cnt, pinsIn.cmpAbove);
        core_d.cnt = core_q.cnt + 4'h1;
        if (core_q.cnt == sadc_pkg::LAST_STEP)
        begin
          doneNow = 1'b1;
          core_d.result = core_d.trial;
          core_d.seq = core_q.cont ? sadc_pkg::SEQ_ARMED : sadc_pkg::SEQ_IDLE;
        end
      end
    end

    // register write once both halves are held
    if (core_q.awHeld && core_q.wHeld)
    begin
      core_d.awHeld = 1'b0;
      core_d.wHeld = 1'b0;
      core_d.rsp.bvalid = 1'b1;
      core_d.rsp.bresp = sadc_pkg::RESP_OKAY;
      if (hitIdx(core_q.awAddr, sadc_pkg::SCR_IDX))
      begin
        if (core_q.wLane0)
        begin
          scrWrite = 1'b1;
          core_d.irqEn = core_q.wData[sadc_pkg::IEN_BIT];
          core_d.cont = core_q.wData[sadc_pkg::CONT_BIT];
          core_d.chan = core_q.wData[sadc_pkg::CHAN_MSB:0];
          // any write rearms unless the selector is all ones, aborting a conversion under way
          core_d.seq = chanOff(core_d.chan) ? sadc_pkg::SEQ_IDLE : sadc_pkg::SEQ_ARMED;
        end
      end
      else if (hitIdx(core_q.awAddr, sadc_pkg::DIV_IDX))
      begin
        if (core_q.wLane0)
          core_d.presc = core_q.wData[sadc_pkg::PRESC_MSB:sadc_pkg::PRESC_LSB];
      end
      else if (!hitIdx(core_q.awAddr, sadc_pkg::RES_IDX))
        core_d.rsp.bresp = sadc_pkg::RESP_SLVERR;
    end

    // register read; the result read has a clearing side effect
    if (axiReq.arvalid && core_q.rsp.arready)
    begin
      core_d.rsp.rvalid = 1'b1;
      core_d.rsp.rresp = sadc_pkg::RESP_OKAY;
      core_d.rsp.rdata = 32'h0000_0000;
      if (hitIdx(axiReq.araddr, sadc_pkg::SCR_IDX))
      begin
        core_d.rsp.rdata[sadc_pkg::FLAG_BIT] = core_q.flag && !core_q.irqEn;
        core_d.rsp.rdata[sadc_pkg::IEN_BIT] = core_q.irqEn;
        core_d.rsp.rdata[sadc_pkg::CONT_BIT] = core_q.cont;
        core_d.rsp.rdata[sadc_pkg::CHAN_MSB:0] = core_q.chan;
      end
      else if (hitIdx(axiReq.araddr, sadc_pkg::RES_IDX))
      begin
        resRead = 1'b1;
        core_d.rsp.rdata[7:0] = core_q.result;
      end
      else if (hitIdx(axiReq.araddr, sadc_pkg::DIV_IDX))
        core_d.rsp.rdata[sadc_pkg::PRESC_MSB:sadc_pkg::PRESC_LSB] = core_q.presc;
      else
        core_d.rsp.rresp = sadc_pkg::RESP_SLVERR;
    end

    // clearing accesses first, so a completion in the same cycle wins
    if (scrWrite || resRead)
    begin
      core_d.flag = 1'b0;
      core_d.pins.irqReq = 1'b0;
    end
    if (doneNow)
    begin
      core_d.flag = 1'b1;
      if (core_q.irqEn)
        core_d.pins.irqReq = 1'b1;
    end

    // one outstanding write and one outstanding read at a time
    core_d.rsp.awready = !core_d.awHeld && !core_d.rsp.bvalid;
    core_d.rsp.wready = !core_d.wHeld && !core_d.rsp.bvalid;
    core_d.rsp.arready = !core_d.rsp.rvalid;

    // analog routing follows the new selector value
    core_d.pins.analogSelect = core_d.chan;
    core_d.pins.converterOn = !chanOff(core_d.chan);
    core_d.pins.portBAnalog = 8'h00;
    core_d.pins.portDLowAnalog = 4'h0;
    if (core_d.chan < sadc_pkg::CHAN_PD_FIRST)
      core_d.pins.portBAnalog[core_d.chan[2:0]] = 1'b1;
    else if (core_d.chan <= sadc_pkg::CHAN_PD_LAST)
      core_d.pins.portDLowAnalog[2'h3 - core_d.chan[1:0]] = 1'b1;
    core_d.pins.dedicatedSel = core_d.chan == sadc_pkg::CHAN_DED;
    core_d.pins.refSupplySel = core_d.chan == sadc_pkg::CHAN_VDD;
    core_d.pins.refGroundSel = core_d.chan == sadc_pkg::CHAN_VSS;
    core_d.pins.sarTrial = core_d.trial;

    // port reads: analog pins show 0 or latch, never the pad
    for (int i = 0; i < 8; i++)
    begin
      if (core_d.pins.portBAnalog[i])
        core_d.pins.portBRead[i] = pinsIn.portBDir[i] && pinsIn.portBLatch[i];
      else
        core_d.pins.portBRead[i] = pinsIn.portBDir[i] ? pinsIn.portBLatch[i] : pinsIn.portBPin[i];
    end
    for (int i = 0; i < 4; i++)
    begin
      if (core_d.pins.portDLowAnalog[i])
        core_d.pins.portDLowRead[i] = pinsIn.portDDir[i] && pinsIn.portDLatch[i];
      else
        core_d.pins.portDLowRead[i] = pinsIn.portDDir[i] ? pinsIn.portDLatch[i] : pinsIn.portDPin[i];
    end
  end

  // reset leaves the converter off with control bits clear
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_q <= '0;
      core_q.rsp.awready <= 1'b1;
      core_q.rsp.wready <= 1'b1;
      core_q.rsp.arready <= 1'b1;
      core_q.chan <= sadc_pkg::SCR_RST[sadc_pkg::CHAN_MSB:0];
      core_q.presc <= sadc_pkg::PRESC_RST;
      core_q.seq <= sadc_pkg::SEQ_IDLE;
      core_q.pins.analogSelect <= sadc_pkg::CHAN_OFF;
    end
    else
      core_q <= core_d;
  end

  assign axiRsp = core_q.rsp;
  assign pinsOut = core_q.pins;

  // converter clock ticks since the conversion began, for checking only
  logic [3:0] convTicks;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      convTicks <= 4'h0;
    else if (core_q.seq != sadc_pkg::SEQ_CONVERT)
      convTicks <= 4'h0;
    else if (tick && !pinsIn.stopMode)
      convTicks <= convTicks + 4'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_conv_length: assert property (doneNow |-> convTicks == sadc_pkg::CONV_CYCLES - 4'h2)
    else $error("conversion did not span fourteen converter clocks");
  a_start_on_tick: assert property (core_q.seq == sadc_pkg::SEQ_ARMED && tick && !pinsIn.stopMode
    && !chanOff(core_q.chan) && !scrWrite |=> core_q.seq == sadc_pkg::SEQ_CONVERT)
    else $error("armed conversion did not start on converter clock");
  a_flag_clear: assert property ((scrWrite || resRead) && !doneNow |=> !core_q.flag)
    else $error("completion flag survived a clearing access");
  a_irq_raise: assert property (doneNow && core_q.irqEn |=> pinsOut.irqReq [*1] ##0 core_q.flag)
    else $error("no interrupt request at conversion end");
  a_irq_hold: assert property (pinsOut.irqReq && !scrWrite && !resRead |=> pinsOut.irqReq)
    else $error("interrupt request dropped without a clearing access");
  a_flag_hidden: assert property (axiReq.arvalid && core_q.rsp.arready
    && hitIdx(axiReq.araddr, sadc_pkg::SCR_IDX) && core_q.irqEn
    |=> !axiRsp.rdata[sadc_pkg::FLAG_BIT])
    else $error("flag visible while interrupt enabled");
  a_power_off: assert property (chanOff(core_q.chan) |-> !pinsOut.converterOn
    && core_q.seq == sadc_pkg::SEQ_IDLE ##1 !doneNow)
    else $error("converter active with selector all ones");
  a_stop_abort: assert property (pinsIn.stopMode && core_q.seq == sadc_pkg::SEQ_CONVERT
    && !scrWrite |=> core_q.seq == sadc_pkg::SEQ_ARMED)
    else $error("stop mode did not abort conversion");
  a_single_shot: assert property (doneNow && !core_q.cont && !scrWrite
    |=> core_q.seq == sadc_pkg::SEQ_IDLE)
    else $error("single conversion did not stop");
  a_cont_repeat: assert property (doneNow && core_q.cont && !scrWrite
    |=> core_q.seq == sadc_pkg::SEQ_ARMED)
    else $error("continuous mode did not rearm");
  a_result_load: assert property (doneNow |=> core_q.result == $past(core_d.trial)
    && core_q.flag)
    else $error("result not loaded at conversion end");

endmodule

// >>> verif/sadc_analog_model.sv
`timescale 1ns/1ps

// comparator and input network behind the converter
module sadc_analog_model
(
  input wire logic mclk,
  input sadc_pkg::sadcPinsOut_t pinsOut,
  input wire logic [7:0] shift,
  output logic cmpAbove
);
  logic [7:0] level;
  logic hit;
  logic flipQ = 1'h0;

  // an unrouted input floats, so the comparator sees noise that moves each cycle
  always @(posedge mclk) flipQ <= ~flipQ;

  // channel level picked by the routed masks only, never by the raw code
  always_comb
  begin
    hit = 1'h1;
    level = 8'h00;
    if (pinsOut.refSupplySel) level = 8'hFF;
    else if (pinsOut.refGroundSel) level = 8'h00;
    else if (pinsOut.dedicatedSel) level = 8'hC3 + shift;
    else if (pinsOut.portBAnalog != 8'h00 || pinsOut.portDLowAnalog != 4'h0)
    begin
      for (int i = 0; i < 8; i++) if (pinsOut.portBAnalog[i]) level = {i[3:0], ~i[3:0]} + shift;
      for (int i = 0; i < 4; i++) if (pinsOut.portDLowAnalog[i]) level = {4'(11 - i), ~4'(11 - i)} + shift;
    end
    else hit = 1'h0;
    cmpAbove = (hit && pinsOut.converterOn) ? (level >= pinsOut.sarTrial) : flipQ;
  end
endmodule

// >>> verif/sar_adc_sequencer_tb.sv
`timescale 1ns/1ps

module sar_adc_sequencer_tb;
  localparam logic [11:0] scrA = {2'h0, sadc_pkg::SCR_IDX, 2'h0};
  localparam logic [11:0] resA = {2'h0, sadc_pkg::RES_IDX, 2'h0};
  localparam logic [11:0] divA = {2'h0, sadc_pkg::DIV_IDX, 2'h0};
  sadc_pkg::sadcAxiReq_t req;
  sadc_pkg::sadcAxiRsp_t rsp;
  sadc_pkg::sadcPinsIn_t pinsDrv;
  sadc_pkg::sadcPinsIn_t pinsIn;
  sadc_pkg::sadcPinsOut_t pout;
  logic mclk;
  logic arst_n;
  logic cmpAbove;
  logic [7:0] shift;
  logic [7:0] prevTrial;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [4:0] c;
  logic [20:0] expMask;
  logic [2:0] ps [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int errCount = 0;
  int nTests = 0;
  int cyc = 0;
  int markAt = 0;
  int markPeriod = 0;
  int markCount = 0;
  int n;
  int div;

  sadc_sequencer dut (.mclk(mclk), .arst_n(arst_n), .axiReq(req), .axiRsp(rsp),
    .pinsIn(pinsIn), .pinsOut(pout));
  sadc_analog_model model (.mclk(mclk), .pinsOut(pout), .shift(shift), .cmpAbove(cmpAbove));

  // comparator output merged into the pin bundle
  always_comb
  begin
    pinsIn = pinsDrv;
    pinsIn.cmpAbove = cmpAbove;
  end

  // clock source
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // msb trial appears at the same step of every conversion, so it times them
  always @(negedge mclk)
  begin
    cyc <= cyc + 1;
    prevTrial <= pout.sarTrial;
    if (pout.sarTrial == 8'h80 && prevTrial != 8'h80)
    begin
      markPeriod <= cyc - markAt;
      markAt <= cyc;
      markCount <= markCount + 1;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict();
    if (errCount == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // handshake state is sampled mid-cycle, released after the edge that took it
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic awHit;
    logic wHit;
    logic bHit;
    @(posedge mclk);
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    bHit = 1'h0;
    while (!bHit)
    begin
      @(negedge mclk);
      awHit = req.awvalid && rsp.awready;
      wHit = req.wvalid && rsp.wready;
      bHit = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge mclk);
      if (awHit) req.awvalid <= 1'h0;
      if (wHit) req.wvalid <= 1'h0;
    end
    req.bready <= 1'h0;
  endtask

  task rdr(input logic [11:0] a);
    logic arHit;
    logic rHit;
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    rHit = 1'h0;
    while (!rHit)
    begin
      @(negedge mclk);
      arHit = req.arvalid && rsp.arready;
      rHit = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge mclk);
      if (arHit) req.arvalid <= 1'h0;
    end
    req.rready <= 1'h0;
  endtask

  // poll status until the done flag shows, bounded
  task wait_flag();
    n = 0;
    rdr(scrA);
    while (!rd[7] && n < 200)
    begin
      rdr(scrA);
      n++;
    end
  endtask

  task wait_marks(input int k);
    int t;
    int w;
    t = markCount + k;
    w = 0;
    while (markCount < t && w < 1000 * k)
    begin
      @(negedge mclk);
      w++;
    end
  endtask

  task wait_irq();
    n = 0;
    while (pout.irqReq !== 1'h1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  function automatic logic [7:0] lvl(input logic [4:0] k);
    if (k == sadc_pkg::CHAN_VDD) return 8'hFF;
    if (k == sadc_pkg::CHAN_VSS) return 8'h00;
    return {k[3:0], ~k[3:0]} + shift;
  endfunction

  // hang guard, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge mclk);
    errCount++;
    give_verdict();
  end

  initial
  begin
    req = '0;
    pinsDrv = '0;
    pinsDrv.portBDir = 8'h0F;
    pinsDrv.portBLatch = 8'hA5;
    pinsDrv.portBPin = 8'hFF;
    pinsDrv.portDDir = 4'h3;
    pinsDrv.portDLatch = 4'hA;
    pinsDrv.portDPin = 4'hF;
    shift = 8'h00;
    arst_n = 1'h0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'h1;
    // reset state and register access kinds
    rdr(scrA);
    check(rd, 32'h1F);
    check({pout.converterOn, pout.irqReq, pout.analogSelect}, {2'h0, 5'h1F});
    rdr(divA);
    check(rd, 32'h00);
    wr(scrA, 8'h9F);
    rdr(scrA);
    check(rd, 32'h1F);
    wr(divA, 8'hFF);
    rdr(divA);
    check(rd, 32'hE0);
    wr(divA, 8'h00);
    wr(resA, 8'h55);
    check(resp, sadc_pkg::RESP_OKAY);
    rdr(resA);
    check(rd, 32'h00);
    rdr(12'h000);
    check(resp, sadc_pkg::RESP_SLVERR);
    // channel codes 0 to 12 and both references: routing, port override, flag, result
    for (int i = 0; i < 15; i++)
    begin
      c = (i < 13) ? 5'(i) : ((i == 13) ? 5'h1D : 5'h1E);
      wr(scrA, {3'h0, c});
      wait_flag();
      check(rd, {27'h0000000, c} | 32'h80);
      expMask = {(c < 8) ? (8'h01 << c) : 8'h00, (c >= 8 && c < 12) ? (4'h1 << (5'hB - c)) : 4'h0,
        c == 5'h0C, c == 5'h1D, c == 5'h1E, 1'h1, c};
      check({pout.portBAnalog, pout.portDLowAnalog, pout.dedicatedSel, pout.refSupplySel,
        pout.refGroundSel, pout.converterOn, pout.analogSelect}, expMask);
      if (c < 8) check(pout.portBRead[c], pinsDrv.portBDir[c] & pinsDrv.portBLatch[c]);
      else if (c < 12) check(pout.portDLowRead[11 - c], pinsDrv.portDDir[11 - c] & pinsDrv.portDLatch[11 - c]);
      rdr(resA);
      check(rd, {24'h000000, lvl(c)});
      rdr(scrA);
      check(rd, {27'h0000000, c});
    end
    // interrupt raise, hold, clear by result read then by control write
    wr(scrA, 8'h47);
    wait_irq();
    check(pout.irqReq, 1'h1);
    rdr(scrA);
    check(rd, 32'h47);
    check(pout.irqReq, 1'h1);
    rdr(resA);
    check(rd, {24'h000000, lvl(5'h07)});
    check(pout.irqReq, 1'h0);
    wr(scrA, 8'h47);
    wait_irq();
    wr(scrA, 8'h1F);
    check({pout.irqReq, pout.converterOn}, 2'h0);
    // conversion period at each divide ratio, continuous mode
    for (int i = 0; i < 6; i++)
    begin
      div = ps[i][2] ? 16 : (1 << ps[i]);
      wr(divA, {ps[i], 5'h00});
      wr(scrA, 8'h23);
      wait_marks(3);
      check(markPeriod, 14 * div);
    end
    // unread results overwritten, then continuous mode switched off
    wr(divA, 8'h00);
    wr(scrA, 8'h23);
    wait_marks(2);
    @(posedge mclk);
    shift <= 8'h20;
    wait_marks(3);
    rdr(scrA);
    check(rd, 32'hA3);
    rdr(resA);
    check(rd, {24'h000000, lvl(5'h03)});
    wr(scrA, 8'h03);
    repeat (100) @(negedge mclk);
    n = markCount;
    repeat (100) @(negedge mclk);
    check(markCount, n);
    // stop mode in mid conversion aborts it, restarts on exit
    wr(divA, 8'h80);
    wr(scrA, 8'h05);
    repeat (120) @(negedge mclk);
    @(posedge mclk);
    pinsDrv.stopMode <= 1'h1;
    repeat (2) @(negedge mclk);
    n = markCount;
    repeat (400) @(negedge mclk);
    check(markCount, n);
    rdr(scrA);
    check(rd, 32'h05);
    @(posedge mclk);
    pinsDrv.stopMode <= 1'h0;
    // software waits out the first conversion after leaving stop
    wait_flag();
    check(rd, 32'h85);
    rdr(resA);
    check(rd, {24'h000000, lvl(5'h05)});
    give_verdict();
  end
endmodule
